// File: rtl/pvc_pkg.sv
// shared constants, types and register map of the process value conditioning block
package pvc_pkg;

	// register byte offsets (one aligned word each)
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_FREQ_LO  = 8'h04;
	localparam logic [7:0] OFS_FREQ_HI  = 8'h08;
	localparam logic [7:0] OFS_ENG_LO   = 8'h0C;
	localparam logic [7:0] OFS_ENG_HI   = 8'h10;
	localparam logic [7:0] OFS_OFFSET   = 8'h14;
	localparam logic [7:0] OFS_FILTER_N = 8'h18;
	localparam logic [7:0] OFS_BO_LO    = 8'h1C;
	localparam logic [7:0] OFS_BO_HI    = 8'h20;
	localparam logic [7:0] OFS_STATUS   = 8'h24;
	localparam logic [7:0] OFS_PV       = 8'h28;

	// control register field positions
	localparam int CTRL_TYPE_LSB = 0;
	localparam int CTRL_UNIT_BIT = 4;
	localparam int CTRL_LIN_BIT  = 5;
	localparam int CTRL_BO_LSB   = 6;
	localparam int CTRL_DP_LSB   = 8;

	// status register field positions
	localparam int ST_LOCK_BIT   = 0;
	localparam int ST_BO_LO_BIT  = 1;
	localparam int ST_BO_HI_BIT  = 2;
	localparam int ST_SEL_BIT    = 3;

	// parameter limits
	localparam logic signed [15:0] VAL_MIN    = 16'sh D8F1; // -9999
	localparam logic signed [15:0] VAL_MAX    = 16'sh 7530; // 30000
	localparam logic signed [15:0] FREQ_MIN   = 16'sh 0000;
	localparam logic [6:0]         FILT_MIN   = 7'h0A;      // 10 samples
	localparam logic [6:0]         FILT_MAX   = 7'h64;      // 100 samples
	localparam logic [2:0]         DP_MAX     = 3'h4;

	// reset values
	localparam logic [10:0]        CTRL_RST   = 11'h000;
	localparam logic signed [15:0] FREQ_HI_RST = 16'sh 2710; // 10000
	localparam logic signed [15:0] ENG_HI_RST = 16'sh 03E8;  // 1000
	localparam logic [6:0]         FILT_RST   = 7'h0A;

	// averaging memory
	localparam int AVG_DEPTH  = 128;
	localparam int AVG_AW     = 7;
	localparam int AVG_W      = 32;

	// timing
	localparam longint CLK_HZ        = 100_000_000;
	localparam longint TICK_MS       = 1;
	localparam longint TICK_CYCLES   = CLK_HZ * TICK_MS / 1000;
	localparam int     LOCK_HOLD_S   = 4;
	localparam logic [11:0] LOCK_HOLD_TICKS = 12'(LOCK_HOLD_S * 1000 / TICK_MS);

	// keys
	localparam int NKEYS   = 5;
	localparam int K_UP    = 0;
	localparam int K_DOWN  = 1;
	localparam int K_ENTER = 2;
	localparam int K_AMB   = 3;
	localparam int K_RAW   = 4;

	typedef enum logic [3:0] {
		IN_TC_J = 4'h0, IN_TC_K = 4'h1, IN_TC_T = 4'h2, IN_TC_R = 4'h3,
		IN_TC_S = 4'h4, IN_TC_E = 4'h5, IN_TC_N = 4'h6, IN_TC_B = 4'h7,
		IN_PT100 = 4'h8, IN_MA020 = 4'h9, IN_MA420 = 4'hA, IN_MV100 = 4'hB,
		IN_V5 = 4'hC, IN_V10 = 4'hD, IN_LOGIC = 4'hE, IN_FREQ = 4'hF
	} pvc_in_type_t;
	localparam logic [3:0] IN_NONE_CODE = 4'hF;

	typedef enum logic [1:0] {
		BO_OFF = 2'h0, BO_LOW = 2'h1, BO_HIGH = 2'h2, BO_BOTH = 2'h3
	} pvc_bo_mode_t;

	typedef enum logic [1:0] {
		SRC_PV = 2'h0, SRC_AMBIENT = 2'h1, SRC_RAW = 2'h2
	} pvc_src_t;

	typedef enum logic [2:0] {
		KP_NORMAL = 3'b001, KP_WAIT_REL = 3'b010, KP_SELECT = 3'b100
	} pvc_kp_state_t;

	typedef struct packed {
		logic [15:0]        freq;   // measured frequency
		logic signed [31:0] value;  // front end result, linearized
		logic signed [31:0] raw;    // same before linearization
	} pvc_sample_t;

	typedef struct packed {
		logic signed [31:0] value;
		logic [2:0]         dp;
		pvc_src_t           src;
		logic               fahrenheit;
	} pvc_disp_t;

endpackage

// File: rtl/pvc_avg_mem.sv
// sample history memory of the averaging filter, registered read
`timescale 1ns/1ps
module pvc_avg_mem
	import pvc_pkg::*;
(
	input  wire logic                  clk,     // system clock
	input  wire logic                  we,      // write enable
	input  wire logic [AVG_AW-1:0]     waddr,   // write address
	input  wire logic [AVG_W-1:0]      wdata,   // write data
	input  wire logic                  re,      // read enable
	input  wire logic [AVG_AW-1:0]     raddr,   // read address
	output logic      [AVG_W-1:0]      rdata    // read data, one cycle later
);
	logic [AVG_W-1:0] mem [AVG_DEPTH];

	// no reset on the array: stale words are masked by the fill count
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (re)
			rdata <= mem[raddr];
	end
endmodule

// File: rtl/pvc_top.sv
// process value conditioning: scaling, offset, mean filter, burn-out, keypad and display select
`timescale 1ns/1ps
module pvc_top
	import pvc_pkg::*;
#(
	parameter longint TICK_DIV = TICK_CYCLES        // cycles per millisecond tick
)
(
	input  wire logic               clk,           // 100 MHz clock
	input  wire logic               rst,           // synchronous reset, active high
	input  wire logic [7:0]         addr,          // register byte address
	input  wire logic [31:0]        wdata,         // register write data
	input  wire logic               wr,            // write strobe
	input  wire logic               rd,            // read strobe
	output logic      [31:0]        rdata,         // read data, cycle after rd
	input  wire logic               sample_valid,  // new acquisition sample
	input  wire pvc_pkg::pvc_sample_t sample,      // acquisition sample
	input  wire logic signed [31:0] ambient_c,     // ambient temperature, celsius
	input  wire logic [NKEYS-1:0]   keys_in,       // keypad pins, high when pressed
	output pvc_pkg::pvc_disp_t      disp,          // display word
	output logic                    locked,        // keypad lock state
	output logic                    config_entry   // one-cycle config entry request
);
	import pvc_pkg::*;

	// configuration registers
	logic [10:0]        ctrl;
	logic signed [15:0] freq_low_limit;
	logic signed [15:0] freq_high_limit;
	logic signed [15:0] eng_range_low;
	logic signed [15:0] eng_range_high;
	logic signed [15:0] indication_offset;
	logic [6:0]         filter_n;
	logic signed [15:0] burnout_low_value;
	logic signed [15:0] burnout_high_value;

	// clamp a written value into a legal range
	function automatic logic signed [15:0] clamp16(input logic [31:0] v,
		input logic signed [15:0] lo, input logic signed [15:0] hi);
		logic signed [31:0] s;
		s = $signed(v);
		if (s < 32'(lo))
			clamp16 = lo;
		else if (s > 32'(hi))
			clamp16 = hi;
		else
			clamp16 = s[15:0];
	endfunction

	// register bus decode
	wire         wr_ctrl   = wr && (addr == OFS_CTRL);
	wire         wr_flo    = wr && (addr == OFS_FREQ_LO);
	wire         wr_fhi    = wr && (addr == OFS_FREQ_HI);
	wire         wr_elo    = wr && (addr == OFS_ENG_LO);
	wire         wr_ehi    = wr && (addr == OFS_ENG_HI);
	wire         wr_ofs    = wr && (addr == OFS_OFFSET);
	wire         wr_filt   = wr && (addr == OFS_FILTER_N);
	wire         wr_blo    = wr && (addr == OFS_BO_LO);
	wire         wr_bhi    = wr && (addr == OFS_BO_HI);
	wire [2:0]   wr_dp     = (wdata[CTRL_DP_LSB +: 3] > DP_MAX) ? DP_MAX : wdata[CTRL_DP_LSB +: 3];
	wire [6:0]   wr_n_raw  = (wdata[31:7] != 25'h0000000) ? FILT_MAX : wdata[6:0];
	wire [6:0]   wr_n      = (wr_n_raw < FILT_MIN) ? FILT_MIN :
	                         (wr_n_raw > FILT_MAX) ? FILT_MAX : wr_n_raw;

	// control field views
	wire pvc_in_type_t  in_type     = pvc_in_type_t'(ctrl[CTRL_TYPE_LSB +: 4]);
	wire                ambient_temp_unit = ctrl[CTRL_UNIT_BIT];
	wire                lin_en      = ctrl[CTRL_LIN_BIT];
	wire pvc_bo_mode_t  burnout_mode = pvc_bo_mode_t'(ctrl[CTRL_BO_LSB +: 2]);
	wire [2:0]          decimal_point_position = ctrl[CTRL_DP_LSB +: 3];

	// configuration writes; out-of-range values are clamped, not rejected
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ctrl               <= CTRL_RST;
			freq_low_limit     <= FREQ_MIN;
			freq_high_limit    <= FREQ_HI_RST;
			eng_range_low      <= 16'sh0000;
			eng_range_high     <= ENG_HI_RST;
			indication_offset  <= 16'sh0000;
			filter_n           <= FILT_RST;
			burnout_low_value  <= 16'sh0000;
			burnout_high_value <= 16'sh0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= {wr_dp, wdata[7:0]};
			if (wr_flo)
				freq_low_limit <= clamp16(wdata, FREQ_MIN, VAL_MAX);
			if (wr_fhi)
				freq_high_limit <= clamp16(wdata, FREQ_MIN, VAL_MAX);
			if (wr_elo)
				eng_range_low <= clamp16(wdata, VAL_MIN, VAL_MAX);
			if (wr_ehi)
				eng_range_high <= clamp16(wdata, VAL_MIN, VAL_MAX);
			if (wr_ofs)
				indication_offset <= clamp16(wdata, VAL_MIN, VAL_MAX);
			if (wr_filt)
				filter_n <= wr_n;
			if (wr_blo)
				burnout_low_value <= clamp16(wdata, VAL_MIN, VAL_MAX);
			if (wr_bhi)
				burnout_high_value <= clamp16(wdata, VAL_MIN, VAL_MAX);
		end
	end

	// keypad: three-stage synchroniser, a change counts once stages two and three agree
	logic [NKEYS-1:0] key_s1;
	logic [NKEYS-1:0] key_s2;
	logic [NKEYS-1:0] key_s3;
	logic [NKEYS-1:0] key;
	logic [NKEYS-1:0] key_q;
	genvar gk;
	generate
		for (gk = 0; gk < NKEYS; gk++)
		begin : g_key
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					key_s1[gk] <= 1'b0;
					key_s2[gk] <= 1'b0;
					key_s3[gk] <= 1'b0;
					key[gk]    <= 1'b0;
					key_q[gk]  <= 1'b0;
				end
				else
				begin
					key_s1[gk] <= keys_in[gk];
					key_s2[gk] <= key_s1[gk];
					key_s3[gk] <= key_s2[gk];
					if (key_s2[gk] == key_s3[gk])
						key[gk] <= key_s3[gk];
					key_q[gk] <= key[gk];
				end
			end
		end
	endgenerate
	wire [NKEYS-1:0] key_press = key & ~key_q;

	// millisecond tick; the hold timer counts ticks so its counter stays small
	logic [31:0] tick_cnt;
	logic        tick;
	always_ff @(posedge clk)
	begin
		if (rst || tick)
			tick_cnt <= 32'h00000000;
		else
			tick_cnt <= tick_cnt + 32'h00000001;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			tick <= 1'b0;
		else
			tick <= (tick_cnt == 32'(TICK_DIV - 2));
	end

	// keypad state machine
	pvc_kp_state_t kp_state;
	pvc_kp_state_t next_kp_state;
	logic [11:0]   hold_cnt;
	logic          lock_choice;
	wire           combo      = key[K_UP] && key[K_DOWN];
	wire           hold_done  = combo && (hold_cnt == LOCK_HOLD_TICKS);
	wire           normal_op  = (kp_state == KP_NORMAL);

	always_comb
	begin
		next_kp_state = kp_state;
		case (kp_state)
			KP_NORMAL:   if (hold_done) next_kp_state = KP_WAIT_REL;
			KP_WAIT_REL: if (!key[K_UP] && !key[K_DOWN]) next_kp_state = KP_SELECT;
			KP_SELECT:   if (key_press[K_ENTER]) next_kp_state = KP_NORMAL;
			default:     next_kp_state = KP_NORMAL;
		endcase
	end

	// hold timer runs only in normal operation; lock holds through lock (unlock path)
	always_ff @(posedge clk)
	begin
		if (rst || !combo || !normal_op)
			hold_cnt <= 12'h000;
		else if (tick && !hold_done)
			hold_cnt <= hold_cnt + 12'h001;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			kp_state    <= KP_NORMAL;
			lock_choice <= 1'b0;
			locked      <= 1'b0;
		end
		else
		begin
			kp_state <= next_kp_state;
			if (kp_state == KP_WAIT_REL)
				lock_choice <= locked;
			else if (kp_state == KP_SELECT && key_press[K_UP])
				lock_choice <= 1'b1;
			else if (kp_state == KP_SELECT && key_press[K_DOWN])
				lock_choice <= 1'b0;
			if (kp_state == KP_SELECT && key_press[K_ENTER])
				locked <= lock_choice;
		end
	end

	// config entry is an enter press without the up/down combo in normal operation, unlocked only
	always_ff @(posedge clk)
	begin
		if (rst)
			config_entry <= 1'b0;
		else
			config_entry <= normal_op && !locked && key_press[K_ENTER] && !combo;
	end

	// stage A: engineering scaling and offset
	wire signed [47:0] f_span  = 48'(freq_high_limit) - 48'(freq_low_limit);
	wire signed [47:0] f_rel   = $signed({32'h00000000, sample.freq}) - 48'(freq_low_limit);
	wire signed [47:0] e_span  = 48'(eng_range_high) - 48'(eng_range_low);
	wire signed [47:0] f_prod  = f_rel * e_span;
	wire signed [47:0] f_quot  = (f_span == 48'sh0) ? 48'sh0 : f_prod / f_span;
	wire signed [31:0] f_eng   = 32'(eng_range_low) + f_quot[31:0];
	wire signed [31:0] lin_val = lin_en ? sample.value : sample.raw;
	wire signed [31:0] eng_val = (in_type == IN_FREQ) ? f_eng :
	                             (in_type == IN_LOGIC) ? ((sample.value != 32'sh0) ?
	                             32'sh1 : 32'sh0) : lin_val;
	wire signed [31:0] ofs_val = eng_val + 32'(indication_offset);

	logic signed [31:0] a_val;
	logic               a_v;
	logic [AVG_AW-1:0]  ptr;
	logic [6:0]         fill;
	logic [6:0]         n_q;
	logic signed [31:0] sum;
	logic [31:0]        old_word;
	logic               b_v;
	logic signed [31:0] mean;
	logic               c_v;
	logic               bo_lo_flag;
	logic               bo_hi_flag;

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			a_val <= 32'sh0;
			a_v   <= 1'b0;
		end
		else
		begin
			a_val <= ofs_val;
			a_v   <= sample_valid && (in_type != IN_NONE_CODE || !ctrl[3] ||
			         in_type == IN_FREQ);
		end
	end

	// stage B: running sum; the oldest word is read while stage A registers
	wire               restart   = (filter_n != n_q);
	wire               full      = (fill == n_q);
	wire signed [31:0] old_val   = full ? $signed(old_word) : 32'sh0;
	wire signed [31:0] next_sum  = sum + a_val - old_val;
	wire [AVG_AW-1:0]  next_ptr  = (ptr == AVG_AW'(n_q - 7'h01)) ? '0 : ptr + 1'b1;
	wire [6:0]         div_n     = full ? n_q : fill + 7'h01;

	pvc_avg_mem u_mem (
		.clk   (clk),
		.we    (a_v && !restart),
		.waddr (ptr),
		.wdata (a_val),
		.re    (sample_valid),
		.raddr (a_v ? next_ptr : ptr),
		.rdata (old_word)
	);

	// a change of N restarts the history, so the mean never mixes two lengths
	always_ff @(posedge clk)
	begin
		if (rst || restart)
		begin
			ptr  <= '0;
			fill <= 7'h00;
			sum  <= 32'sh0;
			n_q  <= rst ? FILT_RST : filter_n;
			b_v  <= 1'b0;
			mean <= 32'sh0;
		end
		else
		begin
			b_v <= a_v;
			if (a_v)
			begin
				sum  <= next_sum;
				ptr  <= next_ptr;
				fill <= full ? fill : fill + 7'h01;
				mean <= next_sum / $signed({25'h0000000, div_n});
			end
		end
	end

	// stage C: burn-out check against the engineering range
	wire mean_lo  = mean < 32'(eng_range_low);
	wire mean_hi  = mean > 32'(eng_range_high);
	wire use_lo   = mean_lo && (burnout_mode == BO_LOW || burnout_mode == BO_BOTH);
	wire use_hi   = mean_hi && (burnout_mode == BO_HIGH || burnout_mode == BO_BOTH);
	wire signed [31:0] pv_next = use_lo ? 32'(burnout_low_value) :
	                             use_hi ? 32'(burnout_high_value) : mean;

	logic signed [31:0] pv;
	logic signed [31:0] raw_hold;
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pv         <= 32'sh0;
			c_v        <= 1'b0;
			bo_lo_flag <= 1'b0;
			bo_hi_flag <= 1'b0;
			raw_hold   <= 32'sh0;
		end
		else
		begin
			c_v <= b_v;
			if (b_v)
			begin
				pv         <= pv_next;
				bo_lo_flag <= use_lo;
				bo_hi_flag <= use_hi;
			end
			if (sample_valid)
				raw_hold <= sample.raw;
		end
	end

	// display select; overrides only while the keypad is in normal operation
	wire               show_amb = normal_op && key[K_AMB];
	wire               show_raw = normal_op && lin_en && key[K_RAW] && !show_amb;
	wire signed [31:0] amb_f    = (ambient_c * 32'sh9) / 32'sh5 + 32'sh20;
	wire signed [31:0] amb_val  = ambient_temp_unit ? amb_f : ambient_c;

	always_ff @(posedge clk)
	begin
		if (rst)
			disp <= '{value: 32'sh0, dp: 3'h0, src: SRC_PV, fahrenheit: 1'b0};
		else
		begin
			disp.value      <= show_amb ? amb_val : show_raw ? raw_hold : pv;
			disp.src        <= show_amb ? SRC_AMBIENT : show_raw ? SRC_RAW : SRC_PV;
			disp.dp         <= show_amb ? 3'h0 : decimal_point_position;
			disp.fahrenheit <= ambient_temp_unit;
		end
	end

	// register read mux, unmapped offsets read zero
	wire [31:0] status_word = {28'h0000000, (kp_state == KP_SELECT), bo_hi_flag,
	                           bo_lo_flag, locked};
	wire [31:0] rd_mux =
		(addr == OFS_CTRL)     ? {21'h000000, ctrl} :
		(addr == OFS_FREQ_LO)  ? 32'(freq_low_limit) :
		(addr == OFS_FREQ_HI)  ? 32'(freq_high_limit) :
		(addr == OFS_ENG_LO)   ? 32'(eng_range_low) :
		(addr == OFS_ENG_HI)   ? 32'(eng_range_high) :
		(addr == OFS_OFFSET)   ? 32'(indication_offset) :
		(addr == OFS_FILTER_N) ? {25'h0000000, filter_n} :
		(addr == OFS_BO_LO)    ? 32'(burnout_low_value) :
		(addr == OFS_BO_HI)    ? 32'(burnout_high_value) :
		(addr == OFS_STATUS)   ? status_word :
		(addr == OFS_PV)       ? pv : 32'h00000000;

	always_ff @(posedge clk)
	begin
		if (rst)
			rdata <= 32'h00000000;
		else
			rdata <= rd ? rd_mux : 32'h00000000;
	end
endmodule

// File: tb/pvc_top_sva.sv
// assertions on the ports of the conditioning block
`timescale 1ns/1ps
module pvc_top_sva
	import pvc_pkg::*;
(
	input wire logic                  clk,          // clock
	input wire logic                  rst,          // sync reset
	input wire logic                  rd,           // read strobe
	input wire logic [31:0]           rdata,        // read data
	input wire logic signed [31:0]    ambient_c,    // ambient, celsius
	input wire logic [NKEYS-1:0]      keys_in,      // key pins
	input wire pvc_pkg::pvc_disp_t    disp,         // display word
	input wire logic                  locked,       // lock state
	input wire logic                  config_entry  // entry pulse
);
	logic [7:0] ent_hist;
	// recent enter samples; the key path delays a press by a few cycles
	always_ff @(posedge clk)
		ent_hist <= {ent_hist[6:0], keys_in[K_ENTER]};
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
	a_amb_shown: assert property (keys_in == 5'h08 [*8] |-> disp.src == SRC_AMBIENT)
		else $error("ambient not shown");
	a_amb_value: assert property (disp.src == SRC_AMBIENT && !disp.fahrenheit && $stable(ambient_c)
		&& $past(ambient_c, 2) == ambient_c |-> disp.value == ambient_c && disp.dp == 3'h0)
		else $error("ambient value wrong");
	a_pv_back: assert property (keys_in == 5'h00 [*8] |-> disp.src == SRC_PV)
		else $error("pv not restored");
	a_entry_pulse: assert property (config_entry |=> !config_entry) else $error("entry too long");
	a_entry_locked: assert property (locked |-> !config_entry)
		else $error("entry while locked");
	a_entry_cause: assert property (config_entry |-> |ent_hist)
		else $error("entry without enter");
	a_lock_cause: assert property (locked != $past(locked) |-> |ent_hist[7:1])
		else $error("lock changed without enter");
	a_dp_range: assert property (disp.dp <= DP_MAX) else $error("dp out of range");
endmodule

// File: tb/pvc_panel_model.sv
// keypad side of the front panel: key pins and a count of entry requests
`timescale 1ns/1ps
module pvc_panel_model
	import pvc_pkg::*;
(
	input wire logic             clk,           // clock
	input wire logic             config_entry,  // entry request
	output logic [NKEYS-1:0]     keys_in        // key pins, high when pressed
);
	int entries = 0;
	initial keys_in = '0;
	// count entry pulses; a pulse held two cycles would count twice
	always @(posedge clk)
		if (config_entry)
			entries <= entries + 1;
	// keys change just after an edge like a real contact would settle
	task set_keys(input logic [NKEYS-1:0] k);
		@(posedge clk);
		keys_in <= k;
	endtask
endmodule

// File: tb/pvc_top_test.sv
// testbench of the conditioning block
`timescale 1ns/1ps
module pvc_top_test;
	import pvc_pkg::*;
	logic              clk, rst, wr, rd, sample_valid;
	logic [7:0]        addr;
	logic [31:0]       wdata, rdata, ex;
	pvc_sample_t       sample;
	logic signed [31:0] ambient_c;
	logic [NKEYS-1:0]  keys_in;
	pvc_disp_t         disp;
	logic              locked, config_entry;
	logic [1:0]        mb;
	int                err_total, samples_checked;
	logic [31:0] rv [12] = '{32'h0, 32'h0, 32'h2710, 32'h0, 32'h3E8, 32'h0, 32'hA, 32'h0,
		32'h0, 32'h0, 32'h0, 32'h0};
	pvc_top #(.TICK_DIV(5)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .sample_valid(sample_valid), .sample(sample),
		.ambient_c(ambient_c), .keys_in(keys_in), .disp(disp), .locked(locked),
		.config_entry(config_entry));
	pvc_panel_model panel (.clk(clk), .config_entry(config_entry), .keys_in(keys_in));
	initial clk = 1'b0;
	always #5 clk = ~clk;
	task complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 check(rdata, e);
	endtask
	task wrchk(input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
		wreg(a, d);
		rchk(a, e);
	endtask
	// only a change of the sample count restarts the history, so step it away and back
	task conf(input logic [31:0] c, input logic [31:0] ofs);
		wreg(OFS_CTRL, c);
		wreg(OFS_OFFSET, ofs);
		wreg(OFS_FILTER_N, 32'hB);
		wreg(OFS_FILTER_N, 32'hA);
	endtask
	task samp(input logic [15:0] f, input logic [31:0] v, input logic [31:0] r);
		@(posedge clk);
		sample <= '{f, v, r};
		sample_valid <= 1'b1;
		@(posedge clk);
		sample_valid <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	initial
	begin
		{rst, wr, rd, sample_valid, addr, wdata, sample} = '0;
		rst = 1'b1;
		ambient_c = 32'h19;
		err_total = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++)
			rchk(8'(i * 4), rv[i]);
		rchk(8'hC3, 32'h0);
		wreg(OFS_STATUS, 32'hF);
		rchk(OFS_STATUS, 32'h0);
		wrchk(OFS_OFFSET, 32'h7FFF, 32'h7530);
		wrchk(OFS_ENG_LO, 32'hFFFFB1E0, 32'hFFFFD8F1);
		wrchk(OFS_FREQ_LO, 32'hFFFFFFFB, 32'h0);
		wrchk(OFS_FILTER_N, 32'h5, 32'hA);
		wrchk(OFS_FILTER_N, 32'hC8, 32'h64);
		wrchk(OFS_CTRL, 32'h700, 32'h400);
		$display("registers done");
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		conf(32'h20F, 32'h5);
		for (int i = 1; i <= 10; i++)
			samp(16'(i * 1000), 32'h0, 32'h0);
		rchk(OFS_PV, 32'h22B);
		samp(16'h0, 32'h0, 32'h0);
		rchk(OFS_PV, 32'h221);
		check(disp.value, 32'h221);
		check(32'(disp.dp), 32'h2);
		$display("scaling done");
		wreg(OFS_BO_LO, 32'hFFFFFFCE);
		wreg(OFS_BO_HI, 32'h7D0);
		for (int m = 0; m < 4; m++)
			for (int s = 0; s < 2; s++)
			begin
				mb = 2'(m);
				conf(32'hF | 32'(m << 6), s ? 32'h64 : 32'hFFFFFF9C);
				// full-scale frequency lands far above the engineering range
				samp(s ? 16'hFFFF : 16'h0, 32'h0, 32'h0);
				ex = s ? (mb[1] ? 32'h7D0 : 32'h19FD) : (mb[0] ? 32'hFFFFFFCE : 32'hFFFFFF9C);
				rchk(OFS_PV, ex);
				rchk(OFS_STATUS, s ? {29'h0, mb[1], 2'h0} : {30'h0, mb[0], 1'h0});
			end
		$display("burn-out done");
		conf(32'h09, 32'h0);
		samp(16'h0, 32'h64, 32'hC8);
		rchk(OFS_PV, 32'hC8);
		conf(32'h0E, 32'h0);
		samp(16'h0, 32'h80000000, 32'h7FFFFFFF);
		rchk(OFS_PV, 32'h1);
		conf(32'h29, 32'h0);
		samp(16'h0, 32'h64, 32'hC8);
		rchk(OFS_PV, 32'h64);
		panel.set_keys(5'h10);
		wt(10);
		check(32'(disp.src), 32'(SRC_RAW));
		check(disp.value, 32'hC8);
		panel.set_keys(5'h00);
		wt(10);
		check(disp.value, 32'h64);
		wreg(OFS_CTRL, 32'h09);
		panel.set_keys(5'h10);
		wt(10);
		check(32'(disp.src), 32'(SRC_PV));
		panel.set_keys(5'h08);
		wt(10);
		check(disp.value, 32'h19);
		wreg(OFS_CTRL, 32'h19);
		ambient_c <= 32'hFFFFFFF6;
		wt(10);
		check(disp.value, 32'hE);
		check(32'(disp.fahrenheit), 32'h1);
		panel.set_keys(5'h00);
		wt(10);
		check(32'(disp.src), 32'(SRC_PV));
		$display("display keys done");
		panel.set_keys(5'h04);
		wt(10);
		panel.set_keys(5'h00);
		wt(10);
		check(32'(panel.entries), 32'h1);
		panel.set_keys(5'h03);
		wt(19000);
		panel.set_keys(5'h00);
		wt(10);
		rchk(OFS_STATUS, 32'h0);
		panel.set_keys(5'h03);
		wt(20100);
		panel.set_keys(5'h00);
		wt(10);
		rchk(OFS_STATUS, 32'h8);
		panel.set_keys(5'h01);
		wt(10);
		panel.set_keys(5'h00);
		wt(10);
		panel.set_keys(5'h04);
		for (int i = 0; i < 20 && locked !== 1'b1; i++)
			@(posedge clk);
		// a lock that never comes counts as a mismatch; the run still ends in the report
		if (locked !== 1'b1)
			err_total++;
		panel.set_keys(5'h00);
		wt(10);
		rchk(OFS_STATUS, 32'h1);
		panel.set_keys(5'h04);
		wt(10);
		panel.set_keys(5'h00);
		wt(10);
		check(32'(panel.entries), 32'h1);
		// the timed two-key hold must still reach lock selection while locked
		panel.set_keys(5'h03);
		wt(20100);
		panel.set_keys(5'h00);
		wt(10);
		rchk(OFS_STATUS, 32'h9);
		panel.set_keys(5'h02);
		wt(10);
		panel.set_keys(5'h00);
		wt(10);
		panel.set_keys(5'h04);
		wt(10);
		panel.set_keys(5'h00);
		wt(10);
		rchk(OFS_STATUS, 32'h0);
		$display("keypad lock done");
		complete_run;
	end
endmodule
bind pvc_top pvc_top_sva chk (.clk(clk), .rst(rst), .rd(rd), .rdata(rdata),
	.ambient_c(ambient_c), .keys_in(keys_in), .disp(disp), .locked(locked),
	.config_entry(config_entry));
